// file: rtl/mcu_core_pkg.sv
// shared constants and carrier types of the 14-bit instruction core
package mcu_core_pkg;

  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;
  localparam int CYCLE_PHASES = 4;
  localparam logic [1:0] LAST_PHASE = 2'h3;

  // byte-register operation codes, word bits 11:8
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_DEC = 4'h3;
  localparam logic [3:0] OP_OR = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_XOR = 4'h6;
  localparam logic [3:0] OP_ADD = 4'h7;
  localparam logic [3:0] OP_MOV = 4'h8;
  localparam logic [3:0] OP_COM = 4'h9;
  localparam logic [3:0] OP_INC = 4'ha;
  localparam logic [3:0] OP_DECSZ = 4'hb;
  localparam logic [3:0] OP_RRC = 4'hc;
  localparam logic [3:0] OP_RLC = 4'hd;
  localparam logic [3:0] OP_SWAP = 4'he;
  localparam logic [3:0] OP_INCSZ = 4'hf;

  // full words of the control group
  localparam logic [7:0] W_RETURN = 8'h08;
  localparam logic [7:0] W_IRQ_RETURN = 8'h09;
  localparam logic [7:0] W_STANDBY = 8'h63;
  localparam logic [7:0] W_WDOG_CLEAR = 8'h64;

  // file register map of the core
  localparam logic [6:0] A_TIMER = 7'h01;
  localparam logic [6:0] A_STATUS = 7'h03;
  localparam logic [6:0] A_PORT = 7'h05;
  localparam logic [6:0] A_HILATCH = 7'h0a;
  localparam logic [6:0] A_IRQCTL = 7'h0b;
  localparam int IRQ_ENABLE_BIT = 7;

  // apb byte addresses
  localparam logic [11:0] R_CTRL = 12'h000;
  localparam logic [11:0] R_ACC = 12'h004;
  localparam logic [11:0] R_PC = 12'h008;
  localparam logic [11:0] R_FLAGS = 12'h00c;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] res;
    logic wr_acc;
    logic wr_f;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic c;
    logic dc;
  } alu_t;

  typedef struct packed {
    logic skip;
    logic jump;
    logic call;
    logic ret;
    logic irq_en_set;
    logic wdog_clear;
    logic standby;
  } ctl_t;

  typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_STANDBY} seq_state_t;

endpackage

// file: rtl/mcu_14bit_instruction_decoder.sv
// decode and execute core for the 14-bit instruction word, with apb status access
`timescale 1ns/10ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - result-target bit 0 writes the accumulator, 1 writes the addressed register.
// - byte words are 00, op code, target bit, 7-bit index; add/and/sub/or/xor codes.
// - decode increment, decrement, complement, move, swap and both rotates.
// - code 0001 clears register or accumulator by bit 7 and sets zero flag.
// - don't-care encoding bits are ignored by the decoder.
// - bit words are 01, sub-op, bit position, register index; 00 clears.
// - bit clear and set force one bit of the register, flags untouched.
// - bit test matching its condition discards the next word, two cycles.
// - decrement/increment-and-skip write result and skip when zero, no flags.
// - add/sub set C, DC, Z; logic, inc, dec, com, move set Z; rotates C.
// - literal words are 11 plus constant; and, or, xor into acc, set Z.
// - call pushes next address, loads 11-bit target plus latch bits, two cycles.
// - jump loads 11-bit target plus latch bits 4:3, no stack, two cycles.
// - watchdog clear resets watchdog only, no prescaler_clear pulse, sets time-out and power-down bits.
// - standby word is one cycle and updates time-out and power-down bits.
// - standby clears watchdog, sets time-out, clears power-down, stops oscillator.
// - both returns and return-with-constant pop the stack into the counter.
// - interrupt return sets global enable; return-with-constant loads acc.
// - counter change or true test costs two cycles, the second a no-op.
// - an I/O port used as source operand reads the pin levels.
// - writing the timer count clears its prescaler when assigned to it.
// - one instruction cycle spans four clock phases.
module mcu_14bit_instruction_decoder #(
  parameter int STACK_N = mcu_core_pkg::STACK_DEPTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [13:0] instr_word,
  output logic [12:0] program_counter,
  input wire logic [7:0] port_pins,
  output logic [7:0] port_latch,
  input wire logic prescaler_on_timer,
  output logic prescaler_clear,
  output logic watchdog_clear,
  output logic osc_stopped,
  input wire logic wake
);

  localparam int SP_W = $clog2(STACK_N);

  logic [1:0] phase_reg;
  logic run_reg;
  mcu_core_pkg::seq_state_t state_reg;
  logic [12:0] program_counter_reg;
  logic [12:0] stack_reg [STACK_N];
  logic [SP_W-1:0] sp_reg;
  logic [7:0] mem_reg [mcu_core_pkg::FILE_DEPTH];
  logic [7:0] acc_reg;
  logic carry_reg;
  logic nibble_overflow_flag;
  logic zero_reg;
  logic timeout_flag_n;
  logic power_down_flag_n;
  logic prescaler_clear_reg;
  logic watchdog_clear_reg;
  logic osc_stopped_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;

  //////////////////////////////////////////////////////////////////////////////
  // fields and operand

  logic [3:0] op4;
  logic dbit;
  logic [6:0] fidx;
  logic [2:0] bpos;
  logic [7:0] lit;
  logic [7:0] fv;
  logic [7:0] status_byte;
  logic [7:0] bit_mask;
  logic [12:0] stack_top;
  logic [12:0] pc_inc;
  logic [12:0] pc_target;
  logic instr_tick;
  logic exec_fire;
  logic byte_res;

  assign op4 = instr_word[11:8];
  assign dbit = instr_word[7];
  assign fidx = instr_word[6:0];
  assign bpos = instr_word[9:7];
  assign lit = instr_word[7:0];
  assign bit_mask = 8'h01 << bpos;
  assign status_byte = {3'h0, timeout_flag_n, power_down_flag_n, zero_reg,
                        nibble_overflow_flag, carry_reg};
  // pins, not the latch, so external drive on an input pin is seen
  assign fv = (fidx == mcu_core_pkg::A_PORT) ? port_pins :
              (fidx == mcu_core_pkg::A_STATUS) ? status_byte : mem_reg[fidx];
  assign stack_top = stack_reg[sp_reg - SP_W'(1)];
  assign pc_inc = program_counter_reg + 13'h0001;
  assign pc_target = {mem_reg[mcu_core_pkg::A_HILATCH][4:3], instr_word[10:0]};
  assign instr_tick = clk_en && (phase_reg == mcu_core_pkg::LAST_PHASE);
  assign exec_fire = instr_tick && run_reg && (state_reg == mcu_core_pkg::ST_EXEC);
  // byte group writes by target bit, except the plain no-op/control words
  assign byte_res = (instr_word[13:12] == 2'h0) && !((op4 == mcu_core_pkg::OP_MISC) && !dbit);

  //////////////////////////////////////////////////////////////////////////////
  // arithmetic

  // returns {digit carry, carry, sum}
  function automatic logic [9:0] addc(input logic [7:0] x, input logic [7:0] y,
                                      input logic ci);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    full = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    addc = {lo[4], full};
  endfunction

  logic [9:0] sum_f;
  logic [9:0] dif_f;
  logic [9:0] sum_k;
  logic [9:0] dif_k;

  assign sum_f = addc(fv, acc_reg, 1'b0);
  assign dif_f = addc(fv, ~acc_reg, 1'b1);
  assign sum_k = addc(lit, acc_reg, 1'b0);
  assign dif_k = addc(lit, ~acc_reg, 1'b1);

  //////////////////////////////////////////////////////////////////////////////
  // decode

  mcu_core_pkg::alu_t al;
  mcu_core_pkg::ctl_t ctl;
  logic res_zero;

  assign res_zero = (al.res == 8'h00);

  always_comb
  begin
    al = '0;
    ctl = '0;
    unique casez (instr_word[13:8])
      6'b00_0000:
      begin
        if (dbit)
          al.res = acc_reg;
        else if (lit == mcu_core_pkg::W_RETURN)
          ctl.ret = 1'b1;
        else if (lit == mcu_core_pkg::W_IRQ_RETURN)
        begin
          ctl.ret = 1'b1;
          ctl.irq_en_set = 1'b1;
        end
        else if (lit == mcu_core_pkg::W_STANDBY)
          ctl.standby = 1'b1;
        else if (lit == mcu_core_pkg::W_WDOG_CLEAR)
          ctl.wdog_clear = 1'b1;
      end
      6'b00_0001:
      begin
        al.res = 8'h00;
        al.upd_z = 1'b1;
      end
      6'b00_0010:
      begin
        {al.dc, al.c, al.res} = dif_f;
        {al.upd_c, al.upd_dc, al.upd_z} = 3'h7;
      end
      6'b00_0011:
      begin
        al.res = fv - 8'h01;
        al.upd_z = 1'b1;
      end
      6'b00_0100:
      begin
        al.res = fv | acc_reg;
        al.upd_z = 1'b1;
      end
      6'b00_0101:
      begin
        al.res = fv & acc_reg;
        al.upd_z = 1'b1;
      end
      6'b00_0110:
      begin
        al.res = fv ^ acc_reg;
        al.upd_z = 1'b1;
      end
      6'b00_0111:
      begin
        {al.dc, al.c, al.res} = sum_f;
        {al.upd_c, al.upd_dc, al.upd_z} = 3'h7;
      end
      6'b00_1000:
      begin
        al.res = fv;
        al.upd_z = 1'b1;
      end
      6'b00_1001:
      begin
        al.res = ~fv;
        al.upd_z = 1'b1;
      end
      6'b00_1010:
      begin
        al.res = fv + 8'h01;
        al.upd_z = 1'b1;
      end
      6'b00_1011:
      begin
        al.res = fv - 8'h01;
        ctl.skip = (al.res == 8'h00);
      end
      6'b00_1100:
      begin
        {al.res, al.c} = {carry_reg, fv};
        al.upd_c = 1'b1;
      end
      6'b00_1101:
      begin
        {al.c, al.res} = {fv, carry_reg};
        al.upd_c = 1'b1;
      end
      6'b00_1110:
        al.res = {fv[3:0], fv[7:4]};
      6'b00_1111:
      begin
        al.res = fv + 8'h01;
        ctl.skip = (al.res == 8'h00);
      end
      6'b01_00??:
      begin
        al.res = fv & ~bit_mask;
        al.wr_f = 1'b1;
      end
      6'b01_01??:
      begin
        al.res = fv | bit_mask;
        al.wr_f = 1'b1;
      end
      6'b01_10??:
        ctl.skip = !fv[bpos];
      6'b01_11??:
        ctl.skip = fv[bpos];
      6'b10_0???:
        ctl.call = 1'b1;
      6'b10_1???:
        ctl.jump = 1'b1;
      6'b11_00??:
      begin
        al.res = lit;
        al.wr_acc = 1'b1;
      end
      6'b11_01??:
      begin
        al.res = lit;
        al.wr_acc = 1'b1;
        ctl.ret = 1'b1;
      end
      6'b11_1000:
      begin
        al.res = lit | acc_reg;
        al.wr_acc = 1'b1;
        al.upd_z = 1'b1;
      end
      6'b11_1001:
      begin
        al.res = lit & acc_reg;
        al.wr_acc = 1'b1;
        al.upd_z = 1'b1;
      end
      6'b11_1010:
      begin
        al.res = lit ^ acc_reg;
        al.wr_acc = 1'b1;
        al.upd_z = 1'b1;
      end
      6'b11_110?:
      begin
        {al.dc, al.c, al.res} = dif_k;
        al.wr_acc = 1'b1;
        {al.upd_c, al.upd_dc, al.upd_z} = 3'h7;
      end
      6'b11_111?:
      begin
        {al.dc, al.c, al.res} = sum_k;
        al.wr_acc = 1'b1;
        {al.upd_c, al.upd_dc, al.upd_z} = 3'h7;
      end
      default:
      begin
        // unassigned literal code 1011 runs as a no-op
      end
    endcase
    if (byte_res)
    begin
      al.wr_acc = !dbit;
      al.wr_f = dbit;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sequencing

  logic redirect;

  assign redirect = ctl.skip || ctl.jump || ctl.call || ctl.ret;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= 2'h0;
    else if (clk_en)
      phase_reg <= phase_reg + 2'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= mcu_core_pkg::ST_EXEC;
    else if (instr_tick && run_reg)
      unique case (state_reg)
        mcu_core_pkg::ST_EXEC:
          if (ctl.standby)
            state_reg <= mcu_core_pkg::ST_STANDBY;
          else if (redirect)
            state_reg <= mcu_core_pkg::ST_FLUSH;
        mcu_core_pkg::ST_FLUSH:
          state_reg <= mcu_core_pkg::ST_EXEC;
        mcu_core_pkg::ST_STANDBY:
          if (wake)
            state_reg <= mcu_core_pkg::ST_EXEC;
        // the fourth code of the state register is unused; recover to execution
        default:
          state_reg <= mcu_core_pkg::ST_EXEC;
      endcase
  end

  // the flush cycle keeps the counter, so the word at the new address runs in the following cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      program_counter_reg <= 13'h0000;
    else if (exec_fire)
      program_counter_reg <= (ctl.jump || ctl.call) ? pc_target :
                             ctl.ret ? stack_top :
                             ctl.skip ? pc_inc + 13'h0001 : pc_inc;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sp_reg <= '0;
      for (int i = 0; i < STACK_N; i++)
        stack_reg[i] <= 13'h0000;
    end
    else if (exec_fire && ctl.call)
    begin
      stack_reg[sp_reg] <= pc_inc;
      sp_reg <= sp_reg + SP_W'(1);
    end
    else if (exec_fire && ctl.ret)
      sp_reg <= sp_reg - SP_W'(1);
  end

  //////////////////////////////////////////////////////////////////////////////
  // results and flags

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= 8'h00;
      for (int i = 0; i < mcu_core_pkg::FILE_DEPTH; i++)
        mem_reg[i] <= 8'h00;
    end
    else if (exec_fire)
    begin
      if (al.wr_acc)
        acc_reg <= al.res;
      if (al.wr_f && fidx != mcu_core_pkg::A_STATUS)
        mem_reg[fidx] <= al.res;
      if (ctl.irq_en_set)
        mem_reg[mcu_core_pkg::A_IRQCTL][mcu_core_pkg::IRQ_ENABLE_BIT] <= 1'b1;
    end
  end

  // an instruction's own flag update wins over a store into the status byte
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {carry_reg, nibble_overflow_flag, zero_reg} <= 3'h0;
    else if (exec_fire)
    begin
      if (al.wr_f && fidx == mcu_core_pkg::A_STATUS)
        {zero_reg, nibble_overflow_flag, carry_reg} <= al.res[2:0];
      if (al.upd_c)
        carry_reg <= al.c;
      if (al.upd_dc)
        nibble_overflow_flag <= al.dc;
      if (al.upd_z)
        zero_reg <= res_zero;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timeout_flag_n <= 1'b1;
      power_down_flag_n <= 1'b1;
    end
    else if (exec_fire && (ctl.wdog_clear || ctl.standby))
    begin
      timeout_flag_n <= 1'b1;
      power_down_flag_n <= ctl.wdog_clear;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prescaler_clear_reg <= 1'b0;
      watchdog_clear_reg <= 1'b0;
      osc_stopped_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      prescaler_clear_reg <= exec_fire && al.wr_f && prescaler_on_timer &&
                             fidx == mcu_core_pkg::A_TIMER;
      watchdog_clear_reg <= exec_fire && (ctl.wdog_clear || ctl.standby);
      osc_stopped_reg <= (state_reg == mcu_core_pkg::ST_STANDBY) ||
                         (exec_fire && ctl.standby);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state

  logic apb_take;
  logic [31:0] rd_data;
  logic rd_hit;

  assign apb_take = psel && penable && !pready_reg;
  assign rd_hit = paddr inside {mcu_core_pkg::R_CTRL, mcu_core_pkg::R_ACC,
                                mcu_core_pkg::R_PC, mcu_core_pkg::R_FLAGS};
  assign rd_data = (paddr == mcu_core_pkg::R_CTRL) ? {31'h0, run_reg} :
                   (paddr == mcu_core_pkg::R_ACC) ? {24'h0, acc_reg} :
                   (paddr == mcu_core_pkg::R_PC) ? {19'h0, program_counter_reg} :
                   (paddr == mcu_core_pkg::R_FLAGS) ? {23'h0, osc_stopped_reg, status_byte} :
                   32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_reg <= mcu_core_pkg::CTRL_RESET[0];
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready_reg <= apb_take;
      pslverr_reg <= apb_take && !rd_hit;
      prdata_reg <= (apb_take && !pwrite) ? rd_data : 32'h0000_0000;
      if (apb_take && pwrite && paddr == mcu_core_pkg::R_CTRL)
        run_reg <= pwdata[0];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign program_counter = program_counter_reg;
  assign port_latch = mem_reg[mcu_core_pkg::A_PORT];
  assign prescaler_clear = prescaler_clear_reg;
  assign watchdog_clear = watchdog_clear_reg;
  assign osc_stopped = osc_stopped_reg;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_acc_target;
    exec_fire && instr_word[13:8] == 6'h07 && !dbit |=>
      acc_reg == $past(sum_f[7:0]);
  endproperty
  a_acc_target: assert property (p_acc_target) else $error("add result not in acc");

  property p_clear_zero;
    exec_fire && instr_word[13:8] == 6'h01 |=> zero_reg;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear left zero flag low");

  property p_skip_flush;
    exec_fire && instr_word[13:10] == 4'h7 && fv[bpos] |=>
      state_reg == mcu_core_pkg::ST_FLUSH &&
      program_counter_reg == $past(program_counter_reg) + 13'h0002;
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("test skip missed");

  property p_jump;
    exec_fire && instr_word[13:11] == 3'h5 |=>
      program_counter_reg == $past(pc_target) && sp_reg == $past(sp_reg);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong");

  property p_call_push;
    exec_fire && instr_word[13:11] == 3'h4 |=>
      stack_reg[$past(sp_reg)] == $past(pc_inc) && sp_reg == $past(sp_reg) + SP_W'(1);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call push wrong");

  property p_return;
    exec_fire && ctl.ret |=> program_counter_reg == $past(stack_top);
  endproperty
  a_return: assert property (p_return) else $error("return address wrong");

  property p_standby;
    exec_fire && instr_word == 14'h0063 |=>
      !power_down_flag_n && timeout_flag_n && watchdog_clear_reg ##1 osc_stopped_reg;
  endproperty
  a_standby: assert property (p_standby) else $error("standby effects wrong");

  property p_wdog;
    exec_fire && instr_word == 14'h0064 |=> power_down_flag_n && timeout_flag_n;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog clear flags wrong");

  property p_sequential;
    exec_fire && !redirect && !ctl.standby |=>
      program_counter_reg == $past(pc_inc) && state_reg == mcu_core_pkg::ST_EXEC;
  endproperty
  a_sequential: assert property (p_sequential) else $error("counter did not step");

  property p_flush_idle;
    instr_tick && run_reg && state_reg == mcu_core_pkg::ST_FLUSH |=>
      $stable(program_counter_reg) && $stable(acc_reg);
  endproperty
  a_flush_idle: assert property (p_flush_idle) else $error("flush cycle not a no-op");

  property p_phase;
    instr_tick |=> phase_reg == 2'h0;
  endproperty
  a_phase: assert property (p_phase) else $error("cycle not four phases");

  c_call: cover property (exec_fire && ctl.call);
  c_skip: cover property (exec_fire && ctl.skip);
  c_standby_wake: cover property (osc_stopped_reg ##[1:40] !osc_stopped_reg);

endmodule

// file: sim/prog_memory.sv
// program memory model that feeds 14-bit words to the core
`timescale 1ns/10ps
module prog_memory (
  input wire logic [12:0] program_counter,
  output logic [13:0] instr_word
);
  logic [13:0] mem [0:31];

  // outside the loaded range the word follows the address, never a stale value
  assign instr_word = (program_counter < 13'h0020) ? mem[program_counter[4:0]]
    : {1'b1, ~program_counter};
endmodule

// file: sim/test_mcu_14bit_instruction_decoder.sv
// self-checking bench for the instruction decode and execute core
`timescale 1ns/10ps
module test_mcu_14bit_instruction_decoder;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic wake = 1'b0;
  logic clk_en = 1'b1;
  logic prescaler_on = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rdata;
  logic pready;
  logic pslverr;
  logic rerr;
  logic prescaler_clear;
  logic watchdog_clear;
  logic osc_stopped;
  logic [12:0] program_counter;
  logic [13:0] instr_word;
  logic [7:0] port_latch;
  int n_fail = 0;
  int cmp_count = 0;
  int n_wd = 0;
  int n_pre = 0;

  always #25 pclk = ~pclk;

  mcu_14bit_instruction_decoder mcu_14bit_instruction_decoder_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instr_word(instr_word), .program_counter(program_counter),
    .port_pins(8'h5a), .port_latch(port_latch), .prescaler_on_timer(prescaler_on),
    .prescaler_clear(prescaler_clear), .watchdog_clear(watchdog_clear),
    .osc_stopped(osc_stopped), .wake(wake)
  );
  prog_memory prog_memory_i (.program_counter(program_counter), .instr_word(instr_word));

  always @(posedge pclk)
  begin
    if (watchdog_clear === 1'b1)
      n_wd++;
    if (prescaler_clear === 1'b1)
      n_pre++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask

  // pready is judged at the rising edge itself, the same value the slave sees there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, rdata, rerr);
    chk(rdata, exp);
  endtask

  task automatic run(input logic [13:0] w[$], input int n);
    for (int i = 0; i < 32; i++)
      prog_memory_i.mem[i] = 14'h0000;
    foreach (w[i])
      prog_memory_i.mem[i] = w[i];
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    n_wd = 0;
    n_pre = 0;
    presetn <= 1'b1;
    apb(1'b1, mcu_core_pkg::R_CTRL, 32'h0000_0001, rdata, rerr);
    repeat (n) @(posedge pclk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_clear_and_bus;
    prescaler_on <= 1'b0;
    run('{14'h3005, 14'h0081, 14'h0155, 14'h2803}, 30);
    rd(mcu_core_pkg::R_ACC, 32'h0000_0000);
    rd(mcu_core_pkg::R_FLAGS, 32'h0000_001c);
    chk(n_pre, 32'h0000_0000);
    prescaler_on <= 1'b1;
    apb(1'b0, 12'h010, 32'h0000_0000, rdata, rerr);
    chk({31'h0, rerr}, 32'h0000_0001);
    chk(rdata, 32'h0000_0000);
  endtask

  task automatic t_arith;
    run('{14'h300f, 14'h3f01, 14'h00a0, 14'h3005, 14'h02a0, 14'h0820, 14'h0085,
      14'h2807}, 8);
    // with the enable low the core must hold its counter, not run ahead
    clk_en <= 1'b0;
    repeat (40) @(posedge pclk);
    chk({19'h0, program_counter}, 32'h0000_0003);
    clk_en <= 1'b1;
    repeat (60) @(posedge pclk);
    rd(mcu_core_pkg::R_ACC, 32'h0000_000b);
    rd(mcu_core_pkg::R_FLAGS, 32'h0000_0019);
    chk({24'h0, port_latch}, 32'h0000_000b);
  endtask

  // skipped words would bump the scratch register, so the final value shows every skip
  task automatic t_flow;
    run('{14'h3001, 14'h00a0, 14'h0ba0, 14'h0aa0, 14'h15a0, 14'h1da0, 14'h0aa0, 14'h2010,
      14'h0620, 14'h0085, 14'h280a, 14'h0, 14'h0, 14'h0, 14'h0, 14'h0, 14'h347e}, 100);
    chk({24'h0, port_latch}, 32'h0000_0076);
    rd(mcu_core_pkg::R_PC, 32'h0000_000a);
    rd(mcu_core_pkg::R_ACC, 32'h0000_0076);
  endtask

  // the register steps feed one another into the final value; the later read of the interrupt control byte overwrites the literal-step results
  task automatic t_logic;
    run('{14'h30c3, 14'h00a1, 14'h09a1, 14'h0ea1, 14'h0da1, 14'h0ca1, 14'h03a1, 14'h10a1,
      14'h18a1, 14'h0aa1, 14'h3cc0, 14'h3903, 14'h3a01, 14'h3880, 14'h2018, 14'h080b,
      14'h0221, 14'h0085, 14'h0f22, 14'h2813, 14'h0, 14'h0, 14'h0, 14'h0, 14'h201a,
      14'h0009, 14'h0008}, 140);
    chk({24'h0, port_latch}, 32'h0000_0040);
    rd(mcu_core_pkg::R_ACC, 32'h0000_0001);
    rd(mcu_core_pkg::R_FLAGS, 32'h0000_001b);
    rd(mcu_core_pkg::R_PC, 32'h0000_0013);
  endtask

  task automatic t_standby;
    run('{14'h0081, 14'h0064, 14'h0063, 14'h0805, 14'h0705, 14'h2805}, 40);
    chk({31'h0, osc_stopped}, 32'h0000_0001);
    rd(mcu_core_pkg::R_FLAGS, 32'h0000_0110);
    rd(mcu_core_pkg::R_PC, 32'h0000_0003);
    chk(n_wd, 32'h0000_0002);
    chk(n_pre, 32'h0000_0001);
    wake <= 1'b1;
    repeat (12) @(posedge pclk);
    wake <= 1'b0;
    repeat (30) @(posedge pclk);
    chk({31'h0, osc_stopped}, 32'h0000_0000);
    rd(mcu_core_pkg::R_ACC, 32'h0000_00b4);
    rd(mcu_core_pkg::R_FLAGS, 32'h0000_0012);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    n_fail++;
    summarize;
  end

  initial
  begin
    t_clear_and_bus;
    t_arith;
    t_flow;
    t_logic;
    t_standby;
    summarize;
  end
endmodule
